// ==== design/uis_power_ctrl.sv ====
// Power sequencing, suspend and resume, line interface modes and endpoint gating.
// Assumes an APB master on the register port and synchronous USB event inputs.
//
// The implementer's own choices: the APB interface to the registers and the address map.
`default_nettype none

module uis_power_ctrl #(
  parameter int ANA_CYC_P = uis_pkg::ANA_DELAY_CYC,
  parameter int SETTLE_CYC_P = uis_pkg::SETTLE_CYC,
  parameter int IDLE_CYC_P = uis_pkg::IDLE_CYC,
  parameter int KDRIVE_CYC_P = uis_pkg::KDRIVE_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic remote_power_select,
  input wire logic power_code_bit0,
  input wire logic power_code_bit1,
  input wire logic busActivity,
  input wire logic usbBusReset,
  input wire logic restoreDefaults,
  input wire logic usbConfigured,
  input wire logic line_signal_detected,
  input wire logic dataEdge,
  input wire logic tokenValid,
  input wire logic [2:0] tokenEp,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic digRegEn,
  output logic anaRegEn,
  output logic oscEnable,
  output logic lineOscEnable,
  output logic lineDetectEnable,
  output logic clocksOn,
  output logic suspended,
  output logic driveResumeK,
  output logic usbCoreReset,
  output logic appReset,
  output logic bitClkEn,
  output uis_pkg::uis_mode_t lineMode,
  output logic [7:0] epEnable,
  output logic epReject,
  output logic [7:0] descAttributes,
  output logic [7:0] descMaxPower
);
  import uis_pkg::*;

  uis_pwr_t pwr_reg, pwr_next;
  uis_mode_t mode_next;
  logic strapTaken_reg, rps_reg, power_code_bit0_reg, power_code_bit1_reg;
  logic [7:0] funcCfg_reg, ctrl_reg;
  logic [6:0] dpll_reg;
  logic [TMR_W-1:0] settleCnt_reg;
  logic [7:0] attr, maxPow;
  logic wakeCapable, pwrDone, idleDone;

  // Straps are caught on the first edge after reset release, never by the reset itself.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strapTaken_reg <= 1'b0;
      rps_reg <= 1'b0;
      power_code_bit0_reg <= 1'b0;
      power_code_bit1_reg <= 1'b0;
    end else if (!strapTaken_reg) begin
      strapTaken_reg <= 1'b1;
      rps_reg <= remote_power_select;
      power_code_bit0_reg <= power_code_bit0;
      power_code_bit1_reg <= power_code_bit1;
    end
  end

  uis_desc_code u_desc (
    .remote_power_select(rps_reg),
    .power_code_bit0(power_code_bit0_reg),
    .power_code_bit1(power_code_bit1_reg),
    .attributes(attr),
    .maxPower(maxPow),
    .wakeCapable(wakeCapable)
  );

  // APB decode; pready is registered, so every access takes exactly one wait state.
  wire apbAccess = psel && penable && pready;
  wire apbPending = psel && penable && !pready;
  wire selFunc = paddr == OFF_FUNC_CFG;
  wire selCtrl = paddr == OFF_CTRL;
  wire selCmd = paddr == OFF_LINE_CMD;
  wire selStat = paddr == OFF_STATUS;
  wire selDesc = paddr == OFF_DESC;
  wire mapped = selFunc || selCtrl || selCmd || selStat || selDesc;
  wire wrFire = apbAccess && pwrite && mapped;
  wire cmdAct = wrFire && selCmd && pwdata[CMD_ACT_BIT];
  wire cmdDeact = wrFire && selCmd && pwdata[CMD_DEACT_BIT];
  wire wakeEn = ctrl_reg[CTRL_WAKE_BIT] && wakeCapable;
  wire oscKeep = funcCfg_reg[FUNC_OSC_KEEP_BIT];
  wire [31:0] statusWord = {16'h0000, epEnable, driveResumeK, wakeCapable, rps_reg, oscEnable,
                            clocksOn, suspended, lineMode};
  wire [31:0] descWord = {FIFO_D_BYTES, FIFO_B_BYTES, descMaxPower, descAttributes};
  wire [31:0] rdMux = selFunc ? {24'h00_0000, funcCfg_reg} :
                      selCtrl ? {24'h00_0000, ctrl_reg} :
                      selStat ? statusWord :
                      selDesc ? descWord : 32'h0000_0000;

  // Bus slave answer registers.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbPending;
      prdata <= (apbPending && !pwrite) ? rdMux : 32'h0000_0000;
      pslverr <= apbPending && !mapped;
    end
  end

  // Software registers; restore clears them, a bus reset does not.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      funcCfg_reg <= FUNC_CFG_RST;
      ctrl_reg <= CTRL_RST;
    end else if (restoreDefaults) begin
      funcCfg_reg <= FUNC_CFG_RST;
      ctrl_reg <= CTRL_RST;
    end else if (wrFire && selFunc) begin
      funcCfg_reg <= pwdata[7:0];
    end else if (wrFire && selCtrl) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // Power state timer and the bus idle timer.
  wire pwrStart = !strapTaken_reg || (pwr_next != pwr_reg);
  wire [TMR_W-1:0] pwrLimit = (pwr_next == PWR_ANA) ? TMR_W'(ANA_CYC_P) :
                              (pwr_next == PWR_SETTLE) ? TMR_W'(SETTLE_CYC_P) :
                              (pwr_next == PWR_KDRIVE) ? TMR_W'(KDRIVE_CYC_P) : TMR_W'(1);
  uis_timer #(.W(TMR_W)) u_pwrTmr (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(pwrStart),
    .limit(pwrLimit),
    .done(pwrDone)
  );
  uis_timer #(.W(TMR_W)) u_idleTmr (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(busActivity || pwr_reg != PWR_RUN),
    .limit(TMR_W'(IDLE_CYC_P)),
    .done(idleDone)
  );

  wire wakeReq = (lineMode == inactive_mode) && line_signal_detected && wakeEn;
  wire resumeDone = (pwr_reg == PWR_SUSP && busActivity) || (pwr_reg == PWR_KDRIVE && pwrDone);

  // Power sequencer: analog wait, clock settle, run, suspend and resume K.
  always_comb begin
    pwr_next = pwr_reg;
    unique case (pwr_reg)
      PWR_ANA: if (pwrDone && strapTaken_reg) pwr_next = PWR_SETTLE;
      PWR_SETTLE: if (pwrDone) pwr_next = PWR_RUN;
      PWR_RUN: if (idleDone) pwr_next = PWR_SUSP;
      PWR_SUSP: begin
        if (busActivity) begin
          pwr_next = oscKeep ? PWR_RUN : PWR_SETTLE;
        end else if (wakeReq) begin
          pwr_next = PWR_KDRIVE;
        end
      end
      PWR_KDRIVE: if (pwrDone) pwr_next = oscKeep ? PWR_RUN : PWR_SETTLE;
      default: pwr_next = PWR_ANA;
    endcase
  end

  // Line interface mode machine.
  always_comb begin
    mode_next = lineMode;
    if (!strapTaken_reg) begin
      mode_next = power_code_bit1 ? inactive_mode : quiet_mode;
    end else if (restoreDefaults || (usbBusReset && power_code_bit1_reg)) begin
      mode_next = power_code_bit1_reg ? inactive_mode : quiet_mode;
    end else begin
      unique case (lineMode)
        quiet_mode: mode_next = quiet_mode;
        inactive_mode: begin
          if (cmdAct && usbConfigured && pwr_reg == PWR_RUN) begin
            mode_next = MODE_ACTIVE;
          end else if (line_signal_detected) begin
            mode_next = (pwr_reg == PWR_RUN) ? MODE_ACTIVE : MODE_WAKING;
          end
        end
        MODE_WAKING: if (resumeDone) mode_next = MODE_ACTIVE;
        MODE_ACTIVE: if (cmdDeact || pwr_next == PWR_SUSP) mode_next = inactive_mode;
      endcase
    end
  end

  wire oscNext = (pwr_next != PWR_ANA) && !(pwr_next == PWR_SUSP && !oscKeep);
  wire [7:0] dpllSum = {1'b0, dpll_reg} + {1'b0, DPLL_STEP};
  wire dpllWrap = dpllSum >= DPLL_WRAP;
  wire [7:0] dpllWrapped = dpllSum - DPLL_WRAP;

  // State registers and their directly registered outputs.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwr_reg <= PWR_ANA;
      lineMode <= quiet_mode;
      digRegEn <= 1'b1;
      anaRegEn <= 1'b0;
      oscEnable <= 1'b0;
      lineOscEnable <= 1'b0;
      lineDetectEnable <= 1'b0;
      clocksOn <= 1'b0;
      suspended <= 1'b0;
      driveResumeK <= 1'b0;
      dpll_reg <= DPLL_HALF;
      bitClkEn <= 1'b0;
    end else begin
      pwr_reg <= pwr_next;
      lineMode <= mode_next;
      digRegEn <= !strapTaken_reg || rps_reg;
      anaRegEn <= rps_reg && (pwr_next != PWR_ANA);
      oscEnable <= oscNext;
      lineOscEnable <= oscNext && (mode_next != quiet_mode);
      lineDetectEnable <= mode_next == inactive_mode;
      clocksOn <= pwr_next == PWR_RUN;
      suspended <= (pwr_next == PWR_SUSP) || (pwr_next == PWR_KDRIVE);
      driveResumeK <= pwr_next == PWR_KDRIVE;
      // The phase restarts mid-bit on every data transition, so drift never builds up.
      if (dataEdge) begin
        dpll_reg <= DPLL_HALF;
      end else begin
        dpll_reg <= dpllWrap ? dpllWrapped[6:0] : dpllSum[6:0];
      end
      bitClkEn <= clocksOn && !dataEdge && dpllWrap;
    end
  end

  // Reset pulses, descriptor bytes and endpoint gating.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      usbCoreReset <= 1'b0;
      appReset <= 1'b0;
      epEnable <= 8'h00;
      epReject <= 1'b0;
      descAttributes <= ATTR_BASE;
      descMaxPower <= MAXP_LOW;
    end else begin
      usbCoreReset <= usbBusReset;
      appReset <= restoreDefaults;
      epEnable <= uisEpMask(ctrl_reg[1:0]);
      epReject <= tokenValid && !epEnable[tokenEp];
      descAttributes <= attr;
      descMaxPower <= maxPow;
    end
  end

  // Cycles spent in the settle state, read only by the checks below.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      settleCnt_reg <= '0;
    end else begin
      settleCnt_reg <= (pwr_reg == PWR_SETTLE) ? settleCnt_reg + TMR_W'(1) : '0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_attr;
    $past(strapTaken_reg) |-> descAttributes == (ATTR_BASE | {1'b0, !rps_reg, power_code_bit1_reg, 5'b00000});
  endproperty
  a_attr: assert property (p_attr) else $error("Attribute byte does not match straps.");
  property p_maxp;
    $past(strapTaken_reg) |-> descMaxPower == ((power_code_bit0_reg && power_code_bit1_reg) ? MAXP_HIGH :
                                               (power_code_bit0_reg || power_code_bit1_reg) ? MAXP_MID : MAXP_LOW);
  endproperty
  a_maxp: assert property (p_maxp) else $error("Maximum power byte does not match straps.");
  property p_hipwr;
    descAttributes[ATTR_WAKE_BIT] |-> descMaxPower != MAXP_LOW;
  endproperty
  a_hipwr: assert property (p_hipwr) else $error("Wake offered by a low-power setup.");
  property p_osc;
    (pwr_reg == PWR_RUN && idleDone && !oscKeep) |=> !oscEnable && suspended;
  endproperty
  a_osc: assert property (p_osc) else $error("Oscillator kept running in suspend.");
  property p_settle;
    (pwr_reg == PWR_SETTLE && pwr_next == PWR_RUN) |-> settleCnt_reg == TMR_W'(SETTLE_CYC_P - 1);
  endproperty
  a_settle: assert property (p_settle) else $error("Clock settle time is wrong.");
  property p_idle;
    (pwr_reg == PWR_RUN && idleDone) |=> pwr_reg == PWR_SUSP;
  endproperty
  a_idle: assert property (p_idle) else $error("Idle bus did not lead to suspend.");
  property p_quiet;
    lineMode == quiet_mode |-> !lineOscEnable && !lineDetectEnable;
  endproperty
  a_quiet: assert property (p_quiet) else $error("Quiet mode feeds the line core.");
  property p_deact;
    (lineMode == MODE_ACTIVE && cmdDeact && !restoreDefaults && !usbBusReset) |=> lineMode == inactive_mode;
  endproperty
  a_deact: assert property (p_deact) else $error("Deactivate left the line active.");
  property p_waking;
    (lineMode == MODE_WAKING && !resumeDone && !restoreDefaults && !usbBusReset) |=> lineMode != MODE_ACTIVE;
  endproperty
  a_waking: assert property (p_waking) else $error("Line active before resume finished.");
  property p_wakesrc;
    $rose(driveResumeK) |-> $past(line_signal_detected) && $past(wakeEn);
  endproperty
  a_wakesrc: assert property (p_wakesrc) else $error("Resume K without line detection.");
  property p_reject;
    (tokenValid && !epEnable[tokenEp]) |=> epReject;
  endproperty
  a_reject: assert property (p_reject) else $error("Disabled endpoint not rejected.");
  property p_epmask;
    strapTaken_reg |-> epEnable == uisEpMask($past(ctrl_reg[1:0]));
  endproperty
  a_epmask: assert property (p_epmask) else $error("Endpoint enables do not match setting.");

  c_suspend: cover property (pwr_reg == PWR_RUN ##1 pwr_reg == PWR_SUSP);
  c_remoteWake: cover property (pwr_reg == PWR_KDRIVE ##1 pwr_reg == PWR_SETTLE);
  c_lineActive: cover property (lineMode == MODE_WAKING ##1 lineMode == MODE_ACTIVE);
  c_reject: cover property (epReject);
endmodule : uis_power_ctrl

`default_nettype wire

// ==== design/uis_pkg.sv ====
// Constants, types and the endpoint decode for the USB power, state and endpoint block.
// Assumes one 100 MHz clock and a single APB master reaching the register map.
`default_nettype none

package uis_pkg;
  localparam int CLK_MHZ = 100;
  localparam int BIT_RATE_MHZ = 12;
  localparam int ANA_DELAY_US = 100;
  localparam int SETTLE_US = 4500;
  localparam int IDLE_US = 3000;
  localparam int KDRIVE_US = 2000;
  localparam int ANA_DELAY_CYC = ANA_DELAY_US * CLK_MHZ;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int IDLE_CYC = IDLE_US * CLK_MHZ;
  localparam int KDRIVE_CYC = KDRIVE_US * CLK_MHZ;
  localparam int TMR_W = 20;
  localparam logic [6:0] DPLL_STEP = 7'(BIT_RATE_MHZ);
  localparam logic [7:0] DPLL_WRAP = 8'(CLK_MHZ);
  localparam logic [6:0] DPLL_HALF = 7'(CLK_MHZ / 2);
  // Register byte offsets.
  localparam logic [7:0] OFF_FUNC_CFG = 8'h00;
  localparam logic [7:0] OFF_CTRL = 8'h04;
  localparam logic [7:0] OFF_LINE_CMD = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_DESC = 8'h10;
  localparam logic [7:0] FUNC_CFG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam int FUNC_OSC_KEEP_BIT = 3;
  localparam int CTRL_WAKE_BIT = 4;
  localparam int CMD_ACT_BIT = 0;
  localparam int CMD_DEACT_BIT = 1;
  // Descriptor coding.
  localparam logic [7:0] ATTR_BASE = 8'h80;
  localparam int ATTR_SELF_BIT = 6;
  localparam int ATTR_WAKE_BIT = 5;
  localparam logic [7:0] MAXP_LOW = 8'h32;
  localparam logic [7:0] MAXP_MID = 8'h96;
  localparam logic [7:0] MAXP_HIGH = 8'hF9;
  // Endpoint numbers and FIFO sizes.
  localparam int EP_CTRL = 0;
  localparam int EP_INTR = 1;
  localparam int EP_B1_OUT = 2;
  localparam int EP_B1_IN = 3;
  localparam int EP_B2_OUT = 4;
  localparam int EP_B2_IN = 5;
  localparam int EP_D_OUT = 6;
  localparam int EP_D_IN = 7;
  localparam logic [7:0] FIFO_B_BYTES = 8'h20;
  localparam logic [7:0] FIFO_D_BYTES = 8'h10;

  typedef enum logic [2:0] {
    PWR_ANA = 3'b000, PWR_SETTLE = 3'b001, PWR_RUN = 3'b011, PWR_SUSP = 3'b010, PWR_KDRIVE = 3'b110
  } uis_pwr_t;

  typedef enum logic [1:0] {
    quiet_mode = 2'b00, inactive_mode = 2'b01, MODE_WAKING = 2'b11, MODE_ACTIVE = 2'b10
  } uis_mode_t;

  // Endpoints enabled by an alternate setting.
  function automatic logic [7:0] uisEpMask(input logic [1:0] alt);
    logic [7:0] m;
    m = 8'h00;
    m[EP_CTRL] = 1'b1;
    m[EP_INTR] = 1'b1;
    if (alt[0]) begin
      m[EP_B1_OUT] = 1'b1;
      m[EP_B1_IN] = 1'b1;
      m[EP_D_OUT] = 1'b1;
      m[EP_D_IN] = 1'b1;
    end
    if (alt[1]) begin
      m[EP_B2_OUT] = 1'b1;
      m[EP_B2_IN] = 1'b1;
      m[EP_D_OUT] = 1'b1;
      m[EP_D_IN] = 1'b1;
    end
    return m;
  endfunction : uisEpMask
endpackage : uis_pkg

`default_nettype wire

// ==== design/uis_timer.sv ====
// Loadable down-counter that flags when a programmed number of cycles has gone by.
// Assumes start is a one-cycle request; done stays high until the next start.
`default_nettype none

module uis_timer #(
  parameter int W = 20
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [W-1:0] limit,
  output logic done
);
  logic [W-1:0] cnt_reg;
  logic run_reg;

  // Done rises exactly limit cycles after the start pulse.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_reg <= '0;
      run_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= limit - W'(1);
      run_reg <= 1'b1;
    end else if (run_reg && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - W'(1);
    end
  end

  assign done = run_reg && (cnt_reg == '0);
endmodule : uis_timer

`default_nettype wire

// ==== design/uis_desc_code.sv ====
// Transcodes the power straps into configuration descriptor bytes.
// Assumes the straps are already held stable by the caller.
`default_nettype none

module uis_desc_code (
  input wire logic remote_power_select,
  input wire logic power_code_bit0,
  input wire logic power_code_bit1,
  output logic [7:0] attributes,
  output logic [7:0] maxPower,
  output logic wakeCapable
);
  import uis_pkg::*;

  assign attributes = ATTR_BASE | {1'b0, ~remote_power_select, power_code_bit1, 5'b00000};
  assign maxPower = (power_code_bit0 && power_code_bit1) ? MAXP_HIGH :
                    (power_code_bit0 || power_code_bit1) ? MAXP_MID : MAXP_LOW;
  // wake in high power only; bit 1 set always implies MAXP_MID or MAXP_HIGH, never MAXP_LOW.
  assign wakeCapable = power_code_bit1;
endmodule : uis_desc_code

`default_nettype wire

// ==== verif/uis_host_model.sv ====
// Host side of the USB link: bus activity, bus reset, configuration and tokens.
// Assumes the bench calls its tasks and that all signals move just after a rising edge.
`default_nettype none
module uis_host_model (
  input wire logic mclk,
  input wire logic epReject,
  output logic busActivity,
  output logic usbBusReset,
  output logic usbConfigured,
  output logic tokenValid,
  output logic [2:0] tokenEp
);
  timeunit 1ns;
  timeprecision 1ps;
  // The bus starts busy and unconfigured, so nothing can suspend before the bench asks.
  initial begin
    busActivity = 1'b1;
    usbBusReset = 1'b0;
    usbConfigured = 1'b0;
    tokenValid = 1'b0;
    tokenEp = 3'h0;
  end
  task automatic setState(input logic act, input logic cfg);
    @(posedge mclk);
    busActivity <= act;
    usbConfigured <= cfg;
  endtask : setState
  task automatic busReset();
    @(posedge mclk);
    usbBusReset <= 1'b1;
    @(posedge mclk);
    usbBusReset <= 1'b0;
  endtask : busReset
  // The endpoint number is inverted once released, so a stale value cannot pass for a live one.
  task automatic token(input logic [2:0] ep, output logic rej);
    @(posedge mclk);
    tokenValid <= 1'b1;
    tokenEp <= ep;
    @(posedge mclk);
    tokenValid <= 1'b0;
    tokenEp <= ~ep;
    @(posedge mclk);
    rej = epReject;
  endtask : token
endmodule : uis_host_model
`default_nettype wire

// ==== verif/test_usb_isdn_power_state_endpoints.sv ====
// Self-checking bench for the power, suspend, line mode and endpoint controller.
// Assumes shortened delay parameters and the host model on the USB side.
`default_nettype none
module test_usb_isdn_power_state_endpoints;
  timeunit 1ns;
  timeprecision 1ps;
  import uis_pkg::*;
  logic mclk, reset_n, rps, pc0, pc1, rstDef, lsd, psel, penable, pwrite, pready, pslverr, err, rej;
  logic busActivity, usbBusReset, usbConfigured, tokenValid, epReject, digRegEn, anaRegEn, oscEnable;
  logic lineOscEnable, lineDetectEnable, clocksOn, suspended, driveResumeK;
  logic dataEdge, usbCoreReset, appReset, bitClkEn;
  logic [7:0] paddr, epEnable, descAttributes, descMaxPower;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] tokenEp;
  uis_mode_t lineMode;
  int miscompares = 0;
  int n_compared = 0;
  int k;
  int nBit;
  uis_power_ctrl #(.ANA_CYC_P(5), .SETTLE_CYC_P(20), .IDLE_CYC_P(30), .KDRIVE_CYC_P(10)) uis_power_ctrl_inst (
    .mclk(mclk), .reset_n(reset_n), .remote_power_select(rps), .power_code_bit0(pc0), .power_code_bit1(pc1),
    .busActivity(busActivity), .usbBusReset(usbBusReset), .restoreDefaults(rstDef), .usbConfigured(usbConfigured),
    .line_signal_detected(lsd), .dataEdge(dataEdge), .tokenValid(tokenValid), .tokenEp(tokenEp), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .digRegEn(digRegEn), .anaRegEn(anaRegEn), .oscEnable(oscEnable),
    .lineOscEnable(lineOscEnable), .lineDetectEnable(lineDetectEnable), .clocksOn(clocksOn),
    .suspended(suspended), .driveResumeK(driveResumeK), .usbCoreReset(usbCoreReset), .appReset(appReset),
    .bitClkEn(bitClkEn),
    .lineMode(lineMode), .epEnable(epEnable), .epReject(epReject), .descAttributes(descAttributes),
    .descMaxPower(descMaxPower));
  uis_host_model uis_host_model_inst (.mclk(mclk), .epReject(epReject), .busActivity(busActivity),
    .usbBusReset(usbBusReset), .usbConfigured(usbConfigured), .tokenValid(tokenValid), .tokenEp(tokenEp));
  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Reference model of the strap coding and the endpoint sets.
  function automatic logic [7:0] expAttr(input int s);
    return 8'h80 | (s[2] ? 8'h00 : 8'h40) | (s[1] ? 8'h20 : 8'h00);
  endfunction : expAttr
  function automatic logic [7:0] expMaxp(input int s);
    return (s[1] && s[0]) ? 8'hF9 : ((s[1] || s[0]) ? 8'h96 : 8'h32);
  endfunction : expMaxp
  function automatic logic [7:0] expMask(input int a);
    logic [7:0] t[4] = '{8'h03, 8'hCF, 8'hF3, 8'hFF};
    return t[a];
  endfunction : expMask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // One APB transfer, held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer.
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic waitFor(input string nm, ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'b1; n++) @(posedge mclk);
    chk(nm, 1, s);
  endtask : waitFor
  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  // Watchdog: the sequence needs well under this many cycles.
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence; the last strap setting is bus powered with both power-code bits set.
  initial begin
    {reset_n, rps, pc0, pc1, rstDef, lsd, dataEdge, psel, penable, pwrite, paddr, pwdata} = '0;
    k = $urandom(32'h04a49c51);
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      reset_n <= 1'b0;
      {rps, pc1, pc0} <= 3'(i);
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      repeat (3) @(posedge mclk);
      chk("attributes", 32'(expAttr(i)), 32'(descAttributes));
      chk("maxPower", 32'(expMaxp(i)), 32'(descMaxPower));
      chk("lineMode", 32'(i[1]), 32'(lineMode));
      chk("digRegEn", 32'(i[2]), 32'(digRegEn));
    end
    chk("anaRegEn early", 0, anaRegEn);
    repeat (15) @(posedge mclk);
    chk("clocksOn early", 0, clocksOn);
    waitFor("clocksOn", clocksOn, 30);
    chk("anaRegEn", 1, anaRegEn);
    // recovered bit rate over one microsecond of clock.
    nBit = 0;
    repeat (CLK_MHZ) begin
      @(posedge mclk);
      nBit += int'(bitClkEn);
    end
    chk("bit clock rate", 32'(BIT_RATE_MHZ), 32'(nBit));
    dataEdge <= 1'b1;
    repeat (3) @(posedge mclk);
    chk("bit clock on data edge", 0, bitClkEn);
    dataEdge <= 1'b0;
    apb(0, OFF_FUNC_CFG, 0);
    chk("func cfg", 0, rd);
    apb(0, 8'h14, 0);
    chk("unmapped err", 1, err);
    for (int a = 0; a < 4; a++) begin
      apb(1, OFF_CTRL, ($urandom() & 32'hFFFF_FF00) | 32'(a));
      repeat (2) @(posedge mclk);
      chk("epEnable", 32'(expMask(a)), 32'(epEnable));
      for (int ep = 0; ep < 8; ep++) begin
        uis_host_model_inst.token(3'(ep), rej);
        chk("epReject", 32'((~expMask(a)) >> ep) & 32'h0000_0001, 32'(rej));
      end
    end
    apb(1, OFF_CTRL, 32'h0000_0013);
    uis_host_model_inst.busReset();
    @(posedge mclk);
    chk("usbCoreReset", 1, usbCoreReset);
    apb(0, OFF_CTRL, 0);
    chk("ctrl after bus reset", 32'h0000_0013, rd);
    @(posedge mclk);
    rstDef <= 1'b1;
    @(posedge mclk);
    rstDef <= 1'b0;
    @(posedge mclk);
    chk("appReset", 1, appReset);
    apb(0, OFF_CTRL, 0);
    chk("ctrl after restore", 0, rd);
    apb(1, OFF_CTRL, 32'h0000_0013);
    apb(1, OFF_LINE_CMD, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk("activate refused", 32'(inactive_mode), 32'(lineMode));
    uis_host_model_inst.setState(1, 1);
    apb(1, OFF_LINE_CMD, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk("activate", 32'(MODE_ACTIVE), 32'(lineMode));
    uis_host_model_inst.setState(0, 1);
    waitFor("suspended", suspended, 60);
    chk("osc stopped", 0, oscEnable);
    chk("suspend powerdown", 32'(inactive_mode), 32'(lineMode));
    lsd <= 1'b1;
    waitFor("resume K", driveResumeK, 5);
    chk("waking", 32'(MODE_WAKING), 32'(lineMode));
    waitFor("recover", clocksOn, 80);
    chk("active after resume", 32'(MODE_ACTIVE), 32'(lineMode));
    lsd <= 1'b0;
    uis_host_model_inst.setState(1, 1);
    apb(1, OFF_LINE_CMD, 32'h0000_0002);
    repeat (2) @(posedge mclk);
    chk("deactivate", 32'(inactive_mode), 32'(lineMode));
    // Suspend with the oscillator kept, then a host resume straight back to run.
    apb(1, OFF_FUNC_CFG, 32'h0000_0008);
    uis_host_model_inst.setState(0, 1);
    waitFor("suspended kept", suspended, 60);
    chk("osc kept", 1, oscEnable);
    uis_host_model_inst.setState(1, 1);
    waitFor("host resume", clocksOn, 3);
    chk("mode after host resume", 32'(inactive_mode), 32'(lineMode));
    uis_host_model_inst.busReset();
    apb(0, OFF_DESC, 0);
    chk("desc", 32'h1020_F9A0, rd);
    tally_and_finish();
  end
endmodule : test_usb_isdn_power_state_endpoints
`default_nettype wire
